// File: dv/dtc_pin_model.sv
`timescale 1ns/1ps
module dtc_pin_model #(
  parameter int HOLD = 16
) (
  input wire logic mclk,
  output logic count_input_a,
  output logic count_input_b,
  output logic ext_irq_pin_a,
  output logic ext_irq_pin_b
);
  initial begin
    count_input_a = 1'b1;
    count_input_b = 1'b1;
    ext_irq_pin_a = 1'b1;
    ext_irq_pin_b = 1'b1;
  end

  // Each level outlasts one machine cycle plus the pin filter delay
  task automatic pulse(input int sel, input int n);
    for (int i = 0; i < n; i++) begin
      repeat (HOLD) @(negedge mclk);
      if (sel == 0) count_input_a = 1'b0; else count_input_b = 1'b0;
      repeat (HOLD) @(negedge mclk);
      if (sel == 0) count_input_a = 1'b1; else count_input_b = 1'b1;
    end
  endtask

  task automatic set_irq(input int sel, input logic v);
    @(negedge mclk);
    if (sel == 0) ext_irq_pin_a = v; else ext_irq_pin_b = v;
  endtask
endmodule

// File: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic mclk;
  logic sysRst;
  logic [2:0] sfrAddr;
  logic sfrWe;
  logic [7:0] sfrWdata;
  logic [7:0] sfrRdata;
  logic pinA, pinB, cntA, cntB;
  logic [3:0] ack;
  logic [3:0] irq;
  int miscompares;
  int nCompared;
  int n;
  time t1;
  time t2;

  dtc_pin_model pins (.mclk(mclk), .count_input_a(cntA),
    .count_input_b(cntB), .ext_irq_pin_a(pinA), .ext_irq_pin_b(pinB));

  dtc_timer_counter #(.MC_CLKS(dtc_pkg::MC_CLKS)) dut (
    .mclk(mclk), .sys_rst(sysRst), .sfrAddr(sfrAddr), .sfrWe(sfrWe),
    .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .ext_irq_pin_a(pinA),
    .ext_irq_pin_b(pinB), .count_input_a(cntA), .count_input_b(cntB),
    .ackOvfCh0(ack[0]), .ackOvfCh1(ack[1]), .ackExtA(ack[2]),
    .ackExtB(ack[3]), .irqOvfCh0(irq[0]), .irqOvfCh1(irq[1]),
    .irqExtA(irq[2]), .irqExtB(irq[3]));

  always #12.5 mclk = ~mclk;

  task automatic close_out();
    $display("compared %0d, mismatches %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    nCompared++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge mclk);
    sfrAddr = a;
    sfrWdata = d;
    sfrWe = 1'b1;
    @(negedge mclk);
    sfrWe = 1'b0;
  endtask

  // Read data is registered, so allow two full cycles after the index
  task automatic rdchk(input logic [2:0] a, input logic [7:0] exp,
                       input string what);
    @(negedge mclk);
    sfrAddr = a;
    repeat (2) @(negedge mclk);
    check(what, sfrRdata, exp);
  endtask

  task automatic ack_pulse(input int i);
    @(negedge mclk);
    ack[i] = 1'b1;
    @(negedge mclk);
    ack[i] = 1'b0;
  endtask

  task automatic wait_irq(input int i, input logic v);
    n = 0;
    while (irq[i] !== v && n < 2000) begin
      @(negedge mclk);
      n++;
    end
    check("irq level", 8'(irq[i]), 8'(v));
  endtask

  task automatic idle(input int c);
    repeat (c) @(negedge mclk);
  endtask

  initial begin
    mclk = 1'b0;
    sysRst = 1'b1;
    sfrAddr = 3'h0;
    sfrWe = 1'b0;
    sfrWdata = 8'h00;
    ack = 4'h0;
    miscompares = 0;
    nCompared = 0;
    idle(6);
    sysRst = 1'b0;
    for (int a = 0; a < 8; a++) begin
      rdchk(a[2:0], 8'h00, "reset value");
    end
    // Reload from 0xFE overflows every second machine cycle
    wr(dtc_pkg::ADDR_MODE_CFG, 8'h22);
    wr(dtc_pkg::ADDR_HIGH_CH0, 8'hFE);
    wr(dtc_pkg::ADDR_LOW_CH0, 8'hFE);
    wr(dtc_pkg::ADDR_RUN_FLAGS, 8'h10);
    wait_irq(0, 1'b1);
    t1 = $time;
    ack_pulse(0);
    check("ack clears", 8'(irq[0]), 8'h00);
    wait_irq(0, 1'b1);
    t2 = $time;
    check("reload period", 8'((t2 - t1) / dtc_pkg::CLK_PERIOD_NS),
          8'(2 * dtc_pkg::MC_CLKS));
    for (int m = 0; m < 2; m++) begin
      wr(dtc_pkg::ADDR_RUN_FLAGS, 8'h00);
      check("sw clear", 8'(irq[0]), 8'h00);
      wr(dtc_pkg::ADDR_MODE_CFG, 8'(m));
      wr(dtc_pkg::ADDR_HIGH_CH0, 8'hFF);
      wr(dtc_pkg::ADDR_LOW_CH0, 8'hFF);
      rdchk(dtc_pkg::ADDR_LOW_CH0, m ? 8'hFF : 8'h1F, "low width");
      wr(dtc_pkg::ADDR_LOW_CH0, 8'hFE);
      wr(dtc_pkg::ADDR_RUN_FLAGS, 8'h10);
      wait_irq(0, 1'b1);
      wr(dtc_pkg::ADDR_RUN_FLAGS, 8'h00);
      idle(30);
      rdchk(dtc_pkg::ADDR_LOW_CH0, 8'h00, "wrap low");
      rdchk(dtc_pkg::ADDR_HIGH_CH0, 8'h00, "wrap high");
    end
    // Split: low byte on run ch0, high byte on run ch1
    wr(dtc_pkg::ADDR_MODE_CFG, 8'h03);
    wr(dtc_pkg::ADDR_LOW_CH0, 8'hFE);
    wr(dtc_pkg::ADDR_HIGH_CH0, 8'hFE);
    wr(dtc_pkg::ADDR_RUN_FLAGS, 8'h10);
    wait_irq(0, 1'b1);
    idle(40);
    check("high idle", 8'(irq[1]), 8'h00);
    wr(dtc_pkg::ADDR_RUN_FLAGS, 8'h50);
    wait_irq(1, 1'b1);
    ack_pulse(1);
    check("ack ch1", 8'(irq[1]), 8'h00);
    wr(dtc_pkg::ADDR_RUN_FLAGS, 8'h00);
    wr(dtc_pkg::ADDR_MODE_CFG, 8'h33);
    wr(dtc_pkg::ADDR_LOW_CH1, 8'h40);
    wr(dtc_pkg::ADDR_RUN_FLAGS, 8'h40);
    idle(60);
    rdchk(dtc_pkg::ADDR_LOW_CH1, 8'h40, "ch1 stopped");
    // Counter operation, then gated by the interrupt pin
    wr(dtc_pkg::ADDR_RUN_FLAGS, 8'h00);
    wr(dtc_pkg::ADDR_MODE_CFG, 8'h05);
    wr(dtc_pkg::ADDR_LOW_CH0, 8'h00);
    wr(dtc_pkg::ADDR_RUN_FLAGS, 8'h10);
    pins.pulse(0, 3);
    idle(40);
    rdchk(dtc_pkg::ADDR_LOW_CH0, 8'h03, "edge count");
    wr(dtc_pkg::ADDR_MODE_CFG, 8'h0D);
    pins.set_irq(0, 1'b0);
    pins.pulse(0, 2);
    idle(40);
    rdchk(dtc_pkg::ADDR_LOW_CH0, 8'h03, "gate low");
    pins.set_irq(0, 1'b1);
    pins.pulse(0, 2);
    idle(40);
    rdchk(dtc_pkg::ADDR_LOW_CH0, 8'h05, "gate high");
    // Channel 1 counts pin b edges, gated by interrupt pin b
    wr(dtc_pkg::ADDR_RUN_FLAGS, 8'h00);
    wr(dtc_pkg::ADDR_MODE_CFG, 8'hD0);
    wr(dtc_pkg::ADDR_LOW_CH1, 8'h00);
    wr(dtc_pkg::ADDR_RUN_FLAGS, 8'h40);
    pins.pulse(1, 2);
    idle(40);
    rdchk(dtc_pkg::ADDR_LOW_CH1, 8'h02, "ch1 edges");
    pins.set_irq(1, 1'b0);
    pins.pulse(1, 2);
    idle(40);
    rdchk(dtc_pkg::ADDR_LOW_CH1, 8'h02, "ch1 gate low");
    pins.set_irq(1, 1'b1);
    idle(10);
    // Pin a edge triggered, pin b level triggered
    wr(dtc_pkg::ADDR_RUN_FLAGS, 8'h01);
    pins.set_irq(0, 1'b0);
    wait_irq(2, 1'b1);
    pins.set_irq(0, 1'b1);
    idle(20);
    check("edge held", 8'(irq[2]), 8'h01);
    ack_pulse(2);
    check("edge ack", 8'(irq[2]), 8'h00);
    pins.set_irq(1, 1'b0);
    wait_irq(3, 1'b1);
    ack_pulse(3);
    check("level ack", 8'(irq[3]), 8'h01);
    pins.set_irq(1, 1'b1);
    wait_irq(3, 1'b0);
    close_out();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    close_out();
  end
endmodule

// File: logic/dtc_pkg.sv
package dtc_pkg;
  // Register indices on the core's special register port
  localparam logic [2:0] ADDR_MODE_CFG = 3'h0;
  localparam logic [2:0] ADDR_RUN_FLAGS = 3'h1;
  localparam logic [2:0] ADDR_LOW_CH0 = 3'h2;
  localparam logic [2:0] ADDR_HIGH_CH0 = 3'h3;
  localparam logic [2:0] ADDR_LOW_CH1 = 3'h4;
  localparam logic [2:0] ADDR_HIGH_CH1 = 3'h5;

  // timer_mode_config fields, channel 1 in the upper nibble
  localparam int GATE_CH1 = 7;
  localparam int CT_CH1 = 6;
  localparam int MODE_HI_CH1 = 5;
  localparam int MODE_LO_CH1 = 4;
  localparam int GATE_CH0 = 3;
  localparam int CT_CH0 = 2;
  localparam int MODE_HI_CH0 = 1;
  localparam int MODE_LO_CH0 = 0;

  // timer_run_and_flags fields
  localparam int OVF_CH1 = 7;
  localparam int RUN_CH1 = 6;
  localparam int OVF_CH0 = 5;
  localparam int RUN_CH0 = 4;
  localparam int EXT_FLAG_B = 3;
  localparam int EXT_TYPE_B = 2;
  localparam int EXT_FLAG_A = 1;
  localparam int EXT_TYPE_A = 0;

  localparam logic [7:0] MODE_CFG_RST = 8'h00;
  localparam logic [7:0] RUN_FLAGS_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;

  localparam logic [1:0] MODE_13BIT = 2'h0;
  localparam logic [1:0] MODE_16BIT = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;

  // Pin index into the synchroniser bank
  localparam int PIN_IRQ_A = 0;
  localparam int PIN_IRQ_B = 1;
  localparam int PIN_CNT_A = 2;
  localparam int PIN_CNT_B = 3;
  localparam int PIN_COUNT = 4;

  localparam int CLK_PERIOD_NS = 25;
  localparam int MACHINE_CYCLE_NS = 300;
  localparam int MC_CLKS = MACHINE_CYCLE_NS / CLK_PERIOD_NS;
endpackage

// File: logic/dtc_timer_counter.sv
// Overview of operation
// - With gating set, a channel counts only while its interrupt pin is high and its run bit is set, counting falling edges in counter operation.
// - The counter/timer select bit chooses pin-edge counting when 1 and machine-cycle counting when 0.
// - Each channel decodes a two-bit mode: 13-bit, 16-bit, 8-bit auto-reload, split/stop.
// - In 13-bit mode the low byte keeps 5 count bits and its upper 3 bits stay zero.
// - In auto-reload mode only the low byte counts and is reloaded from the high byte on overflow.
// - Channel 1 in split mode stops; channel 0 in split mode becomes two 8-bit counters.
// - In split mode the channel 0 low byte uses channel 0 controls and flag, the high byte channel 1 run bit and flag.
// - Overflow flags are set by hardware, cleared by software or when the interrupt is taken.
// - A channel counts only while its run bit is set.
// - An interrupt edge flag is set by a falling edge on its pin and cleared when the interrupt is taken.
// - An interrupt type bit chooses edge or low-level triggering.
// - Timer operation advances once per machine cycle of 12 clocks.
// - A count-input falling edge takes two machine cycles to detect; each level must last one machine cycle.
`timescale 1ns/1ps
module dtc_timer_counter #(
  parameter int MC_CLKS = dtc_pkg::MC_CLKS
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [2:0] sfrAddr,
  input wire logic sfrWe,
  input wire logic [7:0] sfrWdata,
  output logic [7:0] sfrRdata,
  input wire logic ext_irq_pin_a,
  input wire logic ext_irq_pin_b,
  input wire logic count_input_a,
  input wire logic count_input_b,
  input wire logic ackOvfCh0,
  input wire logic ackOvfCh1,
  input wire logic ackExtA,
  input wire logic ackExtB,
  output logic irqOvfCh0,
  output logic irqOvfCh1,
  output logic irqExtA,
  output logic irqExtB
);
  if (MC_CLKS < 2 || MC_CLKS > 255) begin : g_bad_mc
    $error("MC_CLKS out of range");
  end

  localparam int NP = dtc_pkg::PIN_COUNT;

  logic [7:0] timer_mode_config, next_timer_mode_config;
  logic [7:0] timer_run_and_flags, next_timer_run_and_flags;
  logic [7:0] low_count_byte_ch0, next_low_count_byte_ch0;
  logic [7:0] high_count_byte_ch0, next_high_count_byte_ch0;
  logic [7:0] low_count_byte_ch1, next_low_count_byte_ch1;
  logic [7:0] high_count_byte_ch1, next_high_count_byte_ch1;
  logic [7:0] preCnt, next_preCnt;
  logic [NP-1:0] syncA, syncB, syncC, pinFilt, next_pinFilt;
  logic [1:0] cntSamp, next_cntSamp;
  logic [1:0] irqPrev, next_irqPrev;
  logic [7:0] next_sfrRdata;

  logic mcTick, en0, en1, tick0, tick1, tickSplitHi;
  logic [1:0] cntFall, irqFall, mode0, mode1;
  logic ovf0, ovf1, wrMode, wrFlags, wrLo0, wrHi0, wrLo1, wrHi1;
  logic [16:0] step0, step1;

  // One step of a non-split channel: {overflow, high, low}
  function automatic logic [16:0] stepCount(
    input logic [1:0] mode,
    input logic [7:0] lo,
    input logic [7:0] hi,
    input logic tick
  );
    logic [13:0] c13;
    logic [16:0] c16;
    c13 = 14'h0000;
    c16 = 17'h00000;
    stepCount = {1'b0, hi, lo};
    if (tick) begin
      case (mode)
        dtc_pkg::MODE_13BIT: begin
          c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
          stepCount = {c13[13], c13[12:5], 3'h0, c13[4:0]};
        end
        dtc_pkg::MODE_16BIT: begin
          c16 = {1'b0, hi, lo} + 17'h00001;
          stepCount = c16;
        end
        dtc_pkg::MODE_RELOAD: begin
          if (lo == 8'hFF) begin
            stepCount = {1'b1, hi, hi};
          end else begin
            stepCount = {1'b0, hi, lo + 8'h01};
          end
        end
        default: stepCount = {1'b0, hi, lo};
      endcase
    end
  endfunction

  assign mode0 = {timer_mode_config[dtc_pkg::MODE_HI_CH0],
                  timer_mode_config[dtc_pkg::MODE_LO_CH0]};
  assign mode1 = {timer_mode_config[dtc_pkg::MODE_HI_CH1],
                  timer_mode_config[dtc_pkg::MODE_LO_CH1]};
  assign mcTick = (preCnt == 8'(MC_CLKS - 1));
  // Edge seen between two machine-cycle samples
  assign cntFall = cntSamp & ~pinFilt[dtc_pkg::PIN_CNT_B:dtc_pkg::PIN_CNT_A];
  // Interrupt pins are watched every clock for the edge flags
  assign irqFall = irqPrev & ~pinFilt[dtc_pkg::PIN_IRQ_B:dtc_pkg::PIN_IRQ_A];

  assign en0 = timer_run_and_flags[dtc_pkg::RUN_CH0]
      & (~timer_mode_config[dtc_pkg::GATE_CH0]
         | pinFilt[dtc_pkg::PIN_IRQ_A]);
  assign en1 = timer_run_and_flags[dtc_pkg::RUN_CH1]
      & (~timer_mode_config[dtc_pkg::GATE_CH1]
         | pinFilt[dtc_pkg::PIN_IRQ_B]);
  assign tick0 = mcTick & en0
      & (~timer_mode_config[dtc_pkg::CT_CH0] | cntFall[0]);
  assign tick1 = mcTick & en1
      & (~timer_mode_config[dtc_pkg::CT_CH1] | cntFall[1]);
  // Split high byte is a plain timer run by channel 1's run bit
  assign tickSplitHi = mcTick & timer_run_and_flags[dtc_pkg::RUN_CH1];

  assign wrMode = sfrWe && sfrAddr == dtc_pkg::ADDR_MODE_CFG;
  assign wrFlags = sfrWe && sfrAddr == dtc_pkg::ADDR_RUN_FLAGS;
  assign wrLo0 = sfrWe && sfrAddr == dtc_pkg::ADDR_LOW_CH0;
  assign wrHi0 = sfrWe && sfrAddr == dtc_pkg::ADDR_HIGH_CH0;
  assign wrLo1 = sfrWe && sfrAddr == dtc_pkg::ADDR_LOW_CH1;
  assign wrHi1 = sfrWe && sfrAddr == dtc_pkg::ADDR_HIGH_CH1;

  assign irqOvfCh0 = timer_run_and_flags[dtc_pkg::OVF_CH0];
  assign irqOvfCh1 = timer_run_and_flags[dtc_pkg::OVF_CH1];
  assign irqExtA = timer_run_and_flags[dtc_pkg::EXT_FLAG_A];
  assign irqExtB = timer_run_and_flags[dtc_pkg::EXT_FLAG_B];

  // Pins: three flops, a change is taken once stages two and three agree
  always_comb begin
    for (int i = 0; i < NP; i++) begin
      next_pinFilt[i] = (syncB[i] == syncC[i]) ? syncC[i] : pinFilt[i];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      syncA <= '1;
      syncB <= '1;
      syncC <= '1;
      pinFilt <= '1;
    end else begin
      syncA <= {count_input_b, count_input_a, ext_irq_pin_b, ext_irq_pin_a};
      syncB <= syncA;
      syncC <= syncB;
      pinFilt <= next_pinFilt;
    end
  end

  always_comb begin
    next_preCnt = mcTick ? 8'h00 : preCnt + 8'h01;
    next_cntSamp = cntSamp;
    if (mcTick) begin
      // Count inputs sampled once per machine cycle
      next_cntSamp = pinFilt[dtc_pkg::PIN_CNT_B:dtc_pkg::PIN_CNT_A];
    end
    next_irqPrev = pinFilt[dtc_pkg::PIN_IRQ_B:dtc_pkg::PIN_IRQ_A];

    next_timer_mode_config = wrMode ? sfrWdata : timer_mode_config;

    step0 = stepCount(mode0, low_count_byte_ch0, high_count_byte_ch0,
                      tick0);
    step1 = stepCount(mode1, low_count_byte_ch1, high_count_byte_ch1,
                      tick1);
    ovf0 = step0[16];
    ovf1 = step1[16];
    next_low_count_byte_ch0 = step0[7:0];
    next_high_count_byte_ch0 = step0[15:8];
    next_low_count_byte_ch1 = step1[7:0];
    next_high_count_byte_ch1 = step1[15:8];
    if (mode0 == dtc_pkg::MODE_SPLIT) begin
      next_low_count_byte_ch0 = low_count_byte_ch0 + 8'(tick0);
      next_high_count_byte_ch0 = high_count_byte_ch0 + 8'(tickSplitHi);
      ovf0 = tick0 && low_count_byte_ch0 == 8'hFF;
      // Channel 1 keeps counting but its overflow flag now belongs to
      // the split high byte
      ovf1 = tickSplitHi && high_count_byte_ch0 == 8'hFF;
    end

    if (wrLo0) next_low_count_byte_ch0 = sfrWdata;
    if (wrHi0) next_high_count_byte_ch0 = sfrWdata;
    if (wrLo1) next_low_count_byte_ch1 = sfrWdata;
    if (wrHi1) next_high_count_byte_ch1 = sfrWdata;
    // Use the incoming mode so the upper bits never show set
    if (next_timer_mode_config[dtc_pkg::MODE_HI_CH0:dtc_pkg::MODE_LO_CH0]
        == dtc_pkg::MODE_13BIT) next_low_count_byte_ch0[7:5] = 3'h0;
    if (next_timer_mode_config[dtc_pkg::MODE_HI_CH1:dtc_pkg::MODE_LO_CH1]
        == dtc_pkg::MODE_13BIT) next_low_count_byte_ch1[7:5] = 3'h0;

    // Flags: write, then acknowledge clear, then hardware set wins
    next_timer_run_and_flags = wrFlags ? sfrWdata : timer_run_and_flags;
    if (ackOvfCh0) next_timer_run_and_flags[dtc_pkg::OVF_CH0] = 1'b0;
    if (ackOvfCh1) next_timer_run_and_flags[dtc_pkg::OVF_CH1] = 1'b0;
    if (ackExtA) next_timer_run_and_flags[dtc_pkg::EXT_FLAG_A] = 1'b0;
    if (ackExtB) next_timer_run_and_flags[dtc_pkg::EXT_FLAG_B] = 1'b0;
    if (ovf0) next_timer_run_and_flags[dtc_pkg::OVF_CH0] = 1'b1;
    if (ovf1) next_timer_run_and_flags[dtc_pkg::OVF_CH1] = 1'b1;
    if (timer_run_and_flags[dtc_pkg::EXT_TYPE_A]) begin
      if (irqFall[0]) next_timer_run_and_flags[dtc_pkg::EXT_FLAG_A] = 1'b1;
    end else begin
      // Level mode: the flag mirrors the pin, so acks cannot drop it
      next_timer_run_and_flags[dtc_pkg::EXT_FLAG_A] =
          ~pinFilt[dtc_pkg::PIN_IRQ_A];
    end
    if (timer_run_and_flags[dtc_pkg::EXT_TYPE_B]) begin
      if (irqFall[1]) next_timer_run_and_flags[dtc_pkg::EXT_FLAG_B] = 1'b1;
    end else begin
      next_timer_run_and_flags[dtc_pkg::EXT_FLAG_B] =
          ~pinFilt[dtc_pkg::PIN_IRQ_B];
    end

    case (sfrAddr)
      dtc_pkg::ADDR_MODE_CFG: next_sfrRdata = timer_mode_config;
      dtc_pkg::ADDR_RUN_FLAGS: next_sfrRdata = timer_run_and_flags;
      dtc_pkg::ADDR_LOW_CH0: next_sfrRdata = low_count_byte_ch0;
      dtc_pkg::ADDR_HIGH_CH0: next_sfrRdata = high_count_byte_ch0;
      dtc_pkg::ADDR_LOW_CH1: next_sfrRdata = low_count_byte_ch1;
      dtc_pkg::ADDR_HIGH_CH1: next_sfrRdata = high_count_byte_ch1;
      default: next_sfrRdata = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      preCnt <= 8'h00;
      cntSamp <= 2'h3;
      irqPrev <= 2'h3;
      timer_mode_config <= dtc_pkg::MODE_CFG_RST;
      timer_run_and_flags <= dtc_pkg::RUN_FLAGS_RST;
      low_count_byte_ch0 <= dtc_pkg::COUNT_RST;
      high_count_byte_ch0 <= dtc_pkg::COUNT_RST;
      low_count_byte_ch1 <= dtc_pkg::COUNT_RST;
      high_count_byte_ch1 <= dtc_pkg::COUNT_RST;
      sfrRdata <= 8'h00;
    end else begin
      preCnt <= next_preCnt;
      cntSamp <= next_cntSamp;
      irqPrev <= next_irqPrev;
      timer_mode_config <= next_timer_mode_config;
      timer_run_and_flags <= next_timer_run_and_flags;
      low_count_byte_ch0 <= next_low_count_byte_ch0;
      high_count_byte_ch0 <= next_high_count_byte_ch0;
      low_count_byte_ch1 <= next_low_count_byte_ch1;
      high_count_byte_ch1 <= next_high_count_byte_ch1;
      sfrRdata <= next_sfrRdata;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_machine_cycle: assert property (
    mcTick |-> ##12 mcTick)
    else $error("machine cycle is not 12 clocks");

  a_count_16bit: assert property (
    (mode0 == dtc_pkg::MODE_16BIT && tick0 && !wrLo0 && !wrHi0 && !wrMode)
    |=> {high_count_byte_ch0, low_count_byte_ch0}
        == 16'($past({high_count_byte_ch0, low_count_byte_ch0}) + 1))
    else $error("16-bit count did not advance by one");

  a_low_bits_zero: assert property (
    mode1 == dtc_pkg::MODE_13BIT |=> low_count_byte_ch1[7:5] == 3'h0)
    else $error("13-bit low byte upper bits not zero");

  a_reload_copy: assert property (
    (mode0 == dtc_pkg::MODE_RELOAD && tick0
     && low_count_byte_ch0 == 8'hFF && !sfrWe)
    |=> low_count_byte_ch0 == high_count_byte_ch0
        && timer_run_and_flags[dtc_pkg::OVF_CH0])
    else $error("auto-reload did not copy or flag");

  a_split_stop: assert property (
    (mode1 == dtc_pkg::MODE_SPLIT && !wrLo1 && !wrHi1 && !wrMode)
    |=> $stable(low_count_byte_ch1) && $stable(high_count_byte_ch1))
    else $error("channel 1 moved in split mode");

  a_split_high: assert property (
    (mode0 == dtc_pkg::MODE_SPLIT && tickSplitHi && !wrHi0)
    |=> high_count_byte_ch0 == $past(high_count_byte_ch0) + 8'h01)
    else $error("split high byte did not follow channel 1 run");

  a_run_stop: assert property (
    (!timer_run_and_flags[dtc_pkg::RUN_CH0] && !wrLo0 && !wrHi0 && !wrMode)
    |=> $stable(low_count_byte_ch0)
        && ($stable(high_count_byte_ch0)
            || $past(mode0 == dtc_pkg::MODE_SPLIT && tickSplitHi)))
    else $error("channel 0 counted while stopped");

  a_gate_low: assert property (
    (timer_mode_config[dtc_pkg::GATE_CH1] && !pinFilt[dtc_pkg::PIN_IRQ_B]
     && !wrLo1 && !wrHi1 && !wrMode)
    |=> $stable(low_count_byte_ch1) && $stable(high_count_byte_ch1))
    else $error("gated channel 1 counted with pin low");

  a_overflow_flag: assert property (
    (mode0 == dtc_pkg::MODE_16BIT && tick0 && !wrLo0 && !wrHi0
     && {high_count_byte_ch0, low_count_byte_ch0} == 16'hFFFF)
    |=> timer_run_and_flags[dtc_pkg::OVF_CH0]
        && {high_count_byte_ch0, low_count_byte_ch0} == 16'h0000)
    else $error("overflow flag or wrap missing");

  a_edge_flag: assert property (
    (timer_run_and_flags[dtc_pkg::EXT_TYPE_A] && irqFall[0])
    |=> irqExtA)
    else $error("edge flag not set on falling edge");

  a_level_flag: assert property (
    !timer_run_and_flags[dtc_pkg::EXT_TYPE_B]
    |=> irqExtB == !$past(pinFilt[dtc_pkg::PIN_IRQ_B]))
    else $error("level flag does not follow pin");

  a_count_edge: assert property (
    tick0 && timer_mode_config[dtc_pkg::CT_CH0]
    |-> cntSamp[0] && !pinFilt[dtc_pkg::PIN_CNT_A])
    else $error("counter ticked without a falling edge");
endmodule
